/* mesf_top.sv */
// Event status word one with no-load, crossing, reset, dip and overcurrent flags
//
// Notes on behaviour
// - Bit 0 sets on total-power no-load; phases in no-load register bits 2:0.
// - Bit 1 sets on fundamental no-load, phases in 5:3; zero without fundamental.
// - Bit 2 sets on apparent-power no-load; phases in no-load register bits 8:6.
// - Bits 3 to 5 set on missing voltage crossing of phase A, B, C.
// - Bits 6 to 8 set on missing current crossing of phase A, B, C.
// - Bits 9 to 11 set on voltage crossing detected for phase A, B, C.
// - Bits 12 to 14 set on current crossing detected for phase A, B, C.
// - Bit 15 resets to 1, sets after software, hardware reset or power-mode wake.
// - Interrupt output one goes low while bit 15 set; no enable masks it.
// - Bit 16 sets on voltage dip; phases in phase status bits 14:12.
// - Bit 17 sets on overcurrent; phases in phase status bits 5:3.
// - Bit 21 of the status word always reads as 1.
// - Bits 31 to 25 of the status word always read as zero.
`timescale 1ns/1ps
`default_nettype none
module mesf_top #(
  parameter bit HAS_FUNDAMENTAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic total_noload_i,
  input wire logic [2:0] total_noload_phase_i,
  input wire logic fund_noload_i,
  input wire logic [2:0] fund_noload_phase_i,
  input wire logic apparent_noload_i,
  input wire logic [2:0] apparent_noload_phase_i,
  input wire logic [2:0] volt_timeout_i,
  input wire logic [2:0] curr_timeout_i,
  input wire logic [2:0] volt_seen_i,
  input wire logic [2:0] curr_seen_i,
  input wire logic wake_done_i,
  input wire logic dip_i,
  input wire logic [2:0] dip_phase_i,
  input wire logic overcurrent_i,
  input wire logic [2:0] overcurrent_phase_i,
  output logic interrupt_output_one_n_o,
  output logic irq_o,
  output logic software_reset_o
);
  import mesf_pkg::*;

  typedef struct packed {
    logic [17:0] enable;
    logic [2:0] total_ph;
    logic [2:0] fund_ph;
    logic [2:0] app_ph;
    logic [2:0] dip_ph;
    logic [2:0] oc_ph;
    logic software_reset_bit_pend;
    logic [31:0] rdata;
  } mesf_top_t;

  mesf_top_t st_r;
  mesf_top_t st_nxt;
  logic [17:0] flags;
  logic [17:0] set_vec;
  logic [17:0] clr_vec;
  logic [31:0] status_word;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  always_comb begin
    set_vec = '0;
    set_vec[TOTAL_NOLOAD_BIT] = total_noload_i;
    set_vec[FUND_NOLOAD_BIT] = fund_noload_i & HAS_FUNDAMENTAL;
    set_vec[APPARENT_NOLOAD_BIT] = apparent_noload_i;
    set_vec[VOLT_TIMEOUT_LSB +: 3] = volt_timeout_i;
    set_vec[CURR_TIMEOUT_LSB +: 3] = curr_timeout_i;
    set_vec[VOLT_SEEN_LSB +: 3] = volt_seen_i;
    set_vec[CURR_SEEN_LSB +: 3] = curr_seen_i;
    set_vec[RESET_COMPLETE_BIT] = wake_done_i | st_r.software_reset_bit_pend;
    set_vec[DIP_BIT] = dip_i;
    set_vec[OVERCURRENT_BIT] = overcurrent_i;
    clr_vec = (wr_i && hit(addr_i, IRQ_CLEAR_ADDR)) ? wdata_i[17:0] : '0;
  end

  mesf_sticky #(
    .WIDTH(FLAG_W),
    .RESET_VAL(FLAGS_RESET)
  ) u_flags (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .flags_o(flags)
  );

  always_comb begin
    status_word = 32'h00000000;
    status_word[17:0] = flags;
    status_word[RSVD_ONE_BIT] = 1'b1;
    if (!HAS_FUNDAMENTAL) begin
      status_word[FUND_NOLOAD_BIT] = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h00000000;
    // Phase fields latch on their event
    if (total_noload_i) begin
      st_nxt.total_ph = total_noload_phase_i;
    end
    if (fund_noload_i && HAS_FUNDAMENTAL) begin
      st_nxt.fund_ph = fund_noload_phase_i;
    end
    if (apparent_noload_i) begin
      st_nxt.app_ph = apparent_noload_phase_i;
    end
    if (dip_i) begin
      st_nxt.dip_ph = dip_phase_i;
    end
    if (overcurrent_i) begin
      st_nxt.oc_ph = overcurrent_phase_i;
    end
    // Software reset completes one cycle after request
    if (st_r.software_reset_bit_pend) begin
      st_nxt.software_reset_bit_pend = 1'b0;
    end
    if (wr_i) begin
      if (hit(addr_i, IRQ_ENABLE_ADDR)) begin
        st_nxt.enable = wdata_i[17:0];
      end
      if (hit(addr_i, CONFIG_ADDR) && wdata_i[SOFTWARE_RESET_BIT]) begin
        st_nxt.software_reset_bit_pend = 1'b1;
        st_nxt.enable = ENABLE_RESET;
      end
    end
    if (rd_i) begin
      case (addr_i)
        EVENT_STATUS_WORD_ONE_ADDR: begin
          st_nxt.rdata = status_word;
        end
        IRQ_ENABLE_ADDR: begin
          st_nxt.rdata = {14'h0000, st_r.enable};
        end
        NOLOAD_PHASE_REGISTER_ADDR: begin
          st_nxt.rdata = {23'h000000, st_r.app_ph, st_r.fund_ph, st_r.total_ph};
        end
        PHASE_STATUS_REGISTER_ADDR: begin
          st_nxt.rdata = {17'h00000, st_r.dip_ph, 6'h00, st_r.oc_ph, 3'h0};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign interrupt_output_one_n_o = ~flags[RESET_COMPLETE_BIT];
  assign irq_o = |(flags & st_r.enable & ~(18'h1 << RESET_COMPLETE_BIT));
  assign software_reset_o = st_r.software_reset_bit_pend;
endmodule : mesf_top
`default_nettype wire

/* mesf_pkg.sv */
// Package of offsets, fields and reset values for the event status block
package mesf_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] EVENT_STATUS_WORD_ONE_ADDR = 16'hE503;
  localparam logic [15:0] IRQ_ENABLE_ADDR = 16'hE50B;
  localparam logic [15:0] IRQ_CLEAR_ADDR = 16'hE50C;
  localparam logic [15:0] NOLOAD_PHASE_REGISTER_ADDR = 16'hE608;
  localparam logic [15:0] PHASE_STATUS_REGISTER_ADDR = 16'hE600;
  localparam logic [15:0] CONFIG_ADDR = 16'hE618;
  localparam int FLAG_W = 18;
  localparam int TOTAL_NOLOAD_BIT = 0;
  localparam int FUND_NOLOAD_BIT = 1;
  localparam int APPARENT_NOLOAD_BIT = 2;
  localparam int VOLT_TIMEOUT_LSB = 3;
  localparam int CURR_TIMEOUT_LSB = 6;
  localparam int VOLT_SEEN_LSB = 9;
  localparam int CURR_SEEN_LSB = 12;
  localparam int RESET_COMPLETE_BIT = 15;
  localparam int DIP_BIT = 16;
  localparam int OVERCURRENT_BIT = 17;
  localparam int RSVD_ONE_BIT = 21;
  localparam int TOTAL_NOLOAD_LSB = 0;
  localparam int FUND_NOLOAD_LSB = 3;
  localparam int APPARENT_NOLOAD_LSB = 6;
  localparam int OVERCURRENT_PHASE_LSB = 3;
  localparam int DIP_PHASE_LSB = 12;
  localparam int SOFTWARE_RESET_BIT = 7;
  localparam logic [17:0] FLAGS_RESET = 18'h08000;
  localparam logic [17:0] ENABLE_RESET = 18'h00000;
  localparam logic [31:0] RSVD_ONE_MASK = 32'h00200000;
endpackage : mesf_pkg

/* mesf_sticky.sv */
// Sticky flag bank with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module mesf_sticky #(
  parameter int WIDTH = 18,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] flags_o
);
  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } mesf_sticky_t;
  mesf_sticky_t st_r;
  mesf_sticky_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < WIDTH; i++) begin
      // Set beats clear
      st_nxt.flags[i] = set_i[i] | (st_r.flags[i] & ~clr_i[i]);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r.flags <= RESET_VAL;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
  assign flags_o = st_r.flags;
endmodule : mesf_sticky
`default_nettype wire

/* mesf_properties.sv */
// Checker of status word and interrupt pin behaviour
`timescale 1ns/1ps
`default_nettype none
module mesf_properties
  import mesf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic wake_done_i,
  input wire logic interrupt_output_one_n_o,
  input wire logic irq_o,
  input wire logic software_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  logic st_rd, swr, clr15, en_wr;
  assign st_rd = ce_i && rd_i && addr_i == EVENT_STATUS_WORD_ONE_ADDR;
  assign swr = ce_i && wr_i && addr_i == CONFIG_ADDR && wdata_i[SOFTWARE_RESET_BIT];
  assign clr15 = wr_i && addr_i == IRQ_CLEAR_ADDR && wdata_i[RESET_COMPLETE_BIT];
  assign en_wr = ce_i && wr_i && addr_i == IRQ_ENABLE_ADDR;
  AST_RST_PIN: assert property (!rst_n_i && ce_i |=> !interrupt_output_one_n_o)
    else $error("pin not low after reset");
  AST_WAKE_PIN: assert property (disable iff (!rst_n_i) ce_i && wake_done_i |=> !interrupt_output_one_n_o)
    else $error("pin not low after wake");
  AST_SOFTWARE_RESET_BIT_PULSE: assert property (disable iff (!rst_n_i) swr |=> software_reset_o ##1 !interrupt_output_one_n_o)
    else $error("software reset not completed");
  AST_RSVD_ONE: assert property (disable iff (!rst_n_i) st_rd |=> rdata_o[21])
    else $error("reserved one bit low");
  AST_RSVD_ZERO: assert property (disable iff (!rst_n_i) st_rd |=> rdata_o[31:25] == 7'h00)
    else $error("reserved high bits set");
  AST_PIN_STICKY: assert property (disable iff (!rst_n_i) !interrupt_output_one_n_o && !clr15 |=> !interrupt_output_one_n_o)
    else $error("pin released without clear");
  AST_UNMASKABLE: assert property (disable iff (!rst_n_i) en_wr && !wake_done_i && !software_reset_o |=> $stable(interrupt_output_one_n_o))
    else $error("enable write moved pin");
  AST_IRQ_STICKY: assert property (disable iff (!rst_n_i) irq_o && !wr_i |=> irq_o)
    else $error("irq dropped without write");
endmodule : mesf_properties
bind mesf_top mesf_properties i_chk (.*);
`default_nettype wire

/* mesf_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module mesf_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_o,
  output var logic [15:0] addr_i = 16'h0,
  output var logic [31:0] wdata_i = 32'h0,
  output var logic wr_i = 1'h0,
  output var logic rd_i = 1'h0
);
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 d = rdata_o;
  endtask : rd
endmodule : mesf_host
`default_nettype wire

/* mesf_bench.sv */
// Random and directed bench of the event status block
`timescale 1ns/1ps
`default_nettype none
module mesf_bench;
  import mesf_pkg::*;
  logic clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1;
  logic [2:0] total_noload_phase_i = 3'h0, fund_noload_phase_i = 3'h0;
  logic [2:0] apparent_noload_phase_i = 3'h0, dip_phase_i = 3'h0, overcurrent_phase_i = 3'h0;
  logic [17:0] ev = 18'h0, fl, en, v, m;
  int bad_count = 0, n_checks = 0;
  wire logic total_noload_i, fund_noload_i, apparent_noload_i, wake_done_i, dip_i, overcurrent_i;
  wire logic [2:0] volt_timeout_i, curr_timeout_i, volt_seen_i, curr_seen_i;
  wire logic [15:0] addr_i;
  wire logic [31:0] wdata_i, rdata_o;
  wire logic wr_i, rd_i, interrupt_output_one_n_o, irq_o, software_reset_o;
  assign {overcurrent_i, dip_i, wake_done_i, curr_seen_i, volt_seen_i, curr_timeout_i,
    volt_timeout_i, apparent_noload_i, fund_noload_i, total_noload_i} = ev;
  always #10 clk_i = ~clk_i;
  mesf_host i_host (.*);
  mesf_top i_dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask : rdchk
  task automatic pins;
    #1 chk({irq_o, interrupt_output_one_n_o}, {|(fl & en & 18'h37FFF), ~fl[15]});
  endtask : pins
  task automatic pulse(input logic [17:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 18'h0;
    fl = fl | e;
  endtask : pulse
  function automatic logic [31:0] stw();
    return RSVD_ONE_MASK | {14'h0, fl};
  endfunction : stw
  task automatic results;
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #(3000 * 20);
    bad_count++;
    results;
  end
  initial begin
    void'($urandom(52));
    fl = FLAGS_RESET;
    en = ENABLE_RESET;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rdchk(EVENT_STATUS_WORD_ONE_ADDR, 32'h00208000);
    pins;
    {total_noload_phase_i, fund_noload_phase_i, apparent_noload_phase_i} <= 9'h0EE;
    {dip_phase_i, overcurrent_phase_i} <= 6'h3A;
    pulse(18'h30007);
    rdchk(NOLOAD_PHASE_REGISTER_ADDR, 32'h1AB);
    rdchk(PHASE_STATUS_REGISTER_ADDR, 32'h7010);
    rdchk(16'h0000, 32'h0);
    i_host.wr(EVENT_STATUS_WORD_ONE_ADDR, 32'h0);
    rdchk(EVENT_STATUS_WORD_ONE_ADDR, stw());
    repeat (20) begin
      v = 18'($urandom);
      m = 18'($urandom);
      pulse(v);
      rdchk(EVENT_STATUS_WORD_ONE_ADDR, stw());
      en = 18'($urandom);
      i_host.wr(IRQ_ENABLE_ADDR, {14'h0, en});
      pins;
      i_host.wr(IRQ_CLEAR_ADDR, {14'h0, m});
      fl = fl & ~m;
      pins;
      rdchk(EVENT_STATUS_WORD_ONE_ADDR, stw());
    end
    i_host.wr(IRQ_CLEAR_ADDR, 32'h8000);
    fl[15] = 1'h0;
    i_host.wr(CONFIG_ADDR, 32'h80);
    fl[15] = 1'h1;
    rdchk(EVENT_STATUS_WORD_ONE_ADDR, stw());
    rdchk(IRQ_ENABLE_ADDR, 32'h0);
    results;
  end
endmodule : mesf_bench
`default_nettype wire
